//--- tmr8_defines.vh
`ifndef TMR8_DEFINES_VH
`define TMR8_DEFINES_VH

// ****************************************
// register offsets (byte index on the plain port)
// ****************************************
`define TMR8_ADDR_W            3
`define TMR8_OFF_CONTROL       3'h0
`define TMR8_OFF_CLKSEL        3'h1
`define TMR8_OFF_COUNTER       3'h2
`define TMR8_OFF_COMPARE       3'h3
`define TMR8_OFF_IRQ_FLAG      3'h4
`define TMR8_OFF_IRQ_MASK      3'h5
`define TMR8_OFF_ASYNC         3'h6

// ****************************************
// field positions
// ****************************************
`define TMR8_WGM_LSB           0
`define TMR8_WGM_MSB           1
`define TMR8_COM_LSB           4
`define TMR8_COM_MSB           5
`define TMR8_CS_LSB            0
`define TMR8_CS_MSB            2
`define TMR8_BIT_OVF           0
`define TMR8_BIT_CMP           1
`define TMR8_BIT_ASYNC_SEL     3
`define TMR8_BIT_EXT_CLK       4
`define TMR8_BIT_CNT_BUSY      2

// ****************************************
// reset values
// ****************************************
`define TMR8_RST_CONTROL       8'h00
`define TMR8_RST_CLKSEL        3'h0
`define TMR8_RST_COUNTER       8'h00
`define TMR8_RST_COMPARE       8'h00
`define TMR8_RST_FLAGS         2'h0
`define TMR8_RST_MASK          2'h0
`define TMR8_RST_ASYNC         2'h0

// ****************************************
// count limits and modes
// ****************************************
`define TMR8_BOTTOM            8'h00
`define TMR8_MAX               8'hFF
`define TMR8_WGM_NORMAL        2'h0
`define TMR8_WGM_PHASE_PWM     2'h1
`define TMR8_WGM_CTC           2'h2
`define TMR8_WGM_FAST_PWM      2'h3
`define TMR8_COM_NONE          2'h0
`define TMR8_COM_TOGGLE        2'h1
`define TMR8_COM_CLEAR         2'h2
`define TMR8_COM_SET           2'h3
`define TMR8_CS_STOP           3'h0
`define TMR8_PRE_W             10

`endif

//--- tmr8_wave.v
`timescale 1ns/10ps
`include "tmr8_defines.vh"

module tmr8_wave (
    input  wire       sys_clk,
    input  wire       rst_b,
    input  wire       tick,
    input  wire       match_evt,
    input  wire       at_max,
    input  wire       at_bottom,
    input  wire       count_down,
    input  wire [1:0] waveform_mode_field,
    input  wire [1:0] compare_output_mode,
    output wire       oc_state
);

    // ****************************************
    // compare output state
    // ****************************************
    reg  oc_reg;
    reg  oc_next;

    always @* begin
        oc_next = oc_reg;
        case (waveform_mode_field)
            `TMR8_WGM_NORMAL, `TMR8_WGM_CTC: begin
                // non-pwm: act only on a match
                if (match_evt) begin
                    case (compare_output_mode)
                        `TMR8_COM_TOGGLE: oc_next = ~oc_reg;
                        `TMR8_COM_CLEAR:  oc_next = 1'b0;
                        `TMR8_COM_SET:    oc_next = 1'b1;
                        default:          oc_next = oc_reg;
                    endcase
                end
            end
            `TMR8_WGM_FAST_PWM: begin
                // match edge first, bottom restarts the period
                if (compare_output_mode[1]) begin
                    if (match_evt) begin
                        oc_next = compare_output_mode[0];
                    end else if (tick && at_bottom) begin
                        oc_next = ~compare_output_mode[0];
                    end
                end
            end
            `TMR8_WGM_PHASE_PWM: begin
                // direction picks the edge; max alone leaves the level
                if (compare_output_mode[1] && match_evt && !at_max) begin
                    oc_next = compare_output_mode[0] ^ count_down;
                end
            end
            default: oc_next = oc_reg;
        endcase
    end

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            oc_reg <= 1'b0;
        end else begin
            oc_reg <= oc_next;
        end
    end

    assign oc_state = oc_reg;

endmodule

//--- tmr8_core.v
`timescale 1ns/10ps
`include "tmr8_defines.vh"

// Behaviour
// - counter and compare value are 8-bit, readable and writable registers
// - every interrupt request shows in the flag register, gated by mask bits
// - clock select zero stops the tick; counter holds
// - tick from io clock, or crystal oscillator / crystal pin when async selected
// - 0x00 is bottom, 0xFF is maximum
// - top is 0xFF or the compare value depending on mode
// - each tick clears, increments or decrements by mode and direction
// - counter readable and writable whether or not the tick runs
// - software write to counter beats a coincident clear or count
// - two-bit waveform mode field picks the count sequence
// - overflow flag set per mode, usable as interrupt source
// - bottom indication at zero, top indication at maximum, or at compare match in ctc mode
// - compare every cycle; match sets compare flag on next tick
// - compare flag with enable bit set raises compare request
// - compare flag clears when its interrupt is executed
// - writing one to compare flag position clears it
// - waveform generator drives compare output from match, mode and output mode
// - waveform generator uses max and bottom for extreme values
// - normal mode counts up, wraps 0xFF to 0x00, overflow when zero
// - ctc mode clears counter on compare match
// - any counter write blocks compare matches on the next tick
// - output mode zero takes no action on the compare output
module tmr8_core (
    input  wire                    sys_clk,
    input  wire                    rst_b,
    input  wire [`TMR8_ADDR_W-1:0] reg_addr,
    input  wire [7:0]              reg_wdata,
    input  wire                    reg_wr,
    input  wire                    reg_rd,
    output wire [7:0]              reg_rdata,
    input  wire                    crystal_in_pin,
    input  wire                    crystal_osc_clk,
    input  wire                    overflow_irq_ack,
    input  wire                    compare_irq_ack,
    output wire                    overflow_irq,
    output wire                    compare_irq,
    output wire                    compare_output_pin,
    output wire                    compare_output_override,
    output wire                    count_at_top,
    output wire                    count_at_bottom
);

    // ****************************************
    // helpers
    // ****************************************
    // prescaler tap for each clock select value; one table keeps taps in one place
    function tmr8_tap;
        input [2:0]             cs;
        input [`TMR8_PRE_W-1:0] pre;
        begin
            case (cs)
                3'h1:    tmr8_tap = 1'b1;
                3'h2:    tmr8_tap = &pre[2:0];
                3'h3:    tmr8_tap = &pre[4:0];
                3'h4:    tmr8_tap = &pre[5:0];
                3'h5:    tmr8_tap = &pre[6:0];
                3'h6:    tmr8_tap = &pre[7:0];
                3'h7:    tmr8_tap = &pre[9:0];
                default: tmr8_tap = 1'b0;
            endcase
        end
    endfunction

    function tmr8_is_pwm;
        input [1:0] mode;
        begin
            tmr8_is_pwm = (mode == `TMR8_WGM_PHASE_PWM) || (mode == `TMR8_WGM_FAST_PWM);
        end
    endfunction

    // ****************************************
    // registers
    // ****************************************
    reg  [7:0]             timer_control_reg;
    reg  [2:0]             clock_select_reg;
    reg  [7:0]             counter_value_reg;
    reg  [7:0]             counter_value_next;
    reg  [7:0]             compare_value_reg;
    reg  [7:0]             compare_buffer_reg;
    reg  [1:0]             irq_flag_reg;
    reg  [1:0]             irq_mask_reg;
    reg  [1:0]             async_status_reg;
    reg                    count_down_reg;
    reg                    count_down_next;
    reg                    block_reg;
    reg  [`TMR8_PRE_W-1:0] prescale_reg;
    reg  [7:0]             rdata_reg;
    reg  [7:0]             rdata_next;

    // crystal synchronisers: stage one feeds only stage two
    reg                    xpin_s1_reg;
    reg                    xpin_s2_reg;
    reg                    xpin_s3_reg;
    reg                    xosc_s1_reg;
    reg                    xosc_s2_reg;
    reg                    xosc_s3_reg;

    wire [1:0]             waveform_mode_field;
    wire [1:0]             compare_output_mode;
    wire [2:0]             clock_select_field;
    wire                   async_clock_select;
    wire                   ext_clock_select;
    wire                   compare_irq_enable;
    wire                   overflow_irq_enable;
    wire                   wr_control;
    wire                   wr_clksel;
    wire                   wr_counter;
    wire                   wr_compare;
    wire                   wr_flag;
    wire                   wr_mask;
    wire                   wr_async;
    wire                   xpin_rise;
    wire                   xosc_rise;
    wire                   src_pulse;
    wire                   timer_tick;
    wire                   at_max;
    wire                   at_bottom;
    wire                   match;
    wire                   match_evt;
    wire                   ctc_clear;
    wire                   overflow_evt;
    wire                   buffer_load;
    wire                   oc_state;

    assign waveform_mode_field = timer_control_reg[`TMR8_WGM_MSB:`TMR8_WGM_LSB];
    assign compare_output_mode = timer_control_reg[`TMR8_COM_MSB:`TMR8_COM_LSB];
    assign clock_select_field  = clock_select_reg;
    assign async_clock_select  = async_status_reg[0];
    assign ext_clock_select    = async_status_reg[1];
    assign overflow_irq_enable = irq_mask_reg[`TMR8_BIT_OVF];
    assign compare_irq_enable  = irq_mask_reg[`TMR8_BIT_CMP];

    // ****************************************
    // address decode
    // ****************************************
    assign wr_control = reg_wr && (reg_addr == `TMR8_OFF_CONTROL);
    assign wr_clksel  = reg_wr && (reg_addr == `TMR8_OFF_CLKSEL);
    assign wr_counter = reg_wr && (reg_addr == `TMR8_OFF_COUNTER);
    assign wr_compare = reg_wr && (reg_addr == `TMR8_OFF_COMPARE);
    assign wr_flag    = reg_wr && (reg_addr == `TMR8_OFF_IRQ_FLAG);
    assign wr_mask    = reg_wr && (reg_addr == `TMR8_OFF_IRQ_MASK);
    assign wr_async   = reg_wr && (reg_addr == `TMR8_OFF_ASYNC);

    // ****************************************
    // clock source and tick
    // ****************************************
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            xpin_s1_reg <= 1'b0;
            xpin_s2_reg <= 1'b0;
            xpin_s3_reg <= 1'b0;
            xosc_s1_reg <= 1'b0;
            xosc_s2_reg <= 1'b0;
            xosc_s3_reg <= 1'b0;
        end else begin
            xpin_s1_reg <= crystal_in_pin;
            xpin_s2_reg <= xpin_s1_reg;
            xpin_s3_reg <= xpin_s2_reg;
            xosc_s1_reg <= crystal_osc_clk;
            xosc_s2_reg <= xosc_s1_reg;
            xosc_s3_reg <= xosc_s2_reg;
        end
    end

    assign xpin_rise = xpin_s2_reg && !xpin_s3_reg;
    assign xosc_rise = xosc_s2_reg && !xosc_s3_reg;

    // crystal must run below half the io clock or edges are lost
    assign src_pulse = !async_clock_select ? 1'b1 :
                       (ext_clock_select ? xpin_rise : xosc_rise);

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prescale_reg <= {`TMR8_PRE_W{1'b0}};
        end else if (clock_select_field == `TMR8_CS_STOP) begin
            prescale_reg <= {`TMR8_PRE_W{1'b0}};
        end else if (src_pulse) begin
            prescale_reg <= prescale_reg + 1'b1;
        end
    end

    // stop select yields no tick at all
    assign timer_tick = src_pulse && tmr8_tap(clock_select_field, prescale_reg);

    // ****************************************
    // counter unit
    // ****************************************
    assign at_max    = (counter_value_reg == `TMR8_MAX);
    assign at_bottom = (counter_value_reg == `TMR8_BOTTOM);
    assign count_at_top    = (waveform_mode_field == `TMR8_WGM_CTC) ? match : at_max;
    assign count_at_bottom = at_bottom;

    // comparator runs every cycle
    assign match     = (counter_value_reg == compare_value_reg);
    // a counter write blocks the match of the following tick, even when stopped
    assign match_evt = timer_tick && match && !block_reg && !wr_counter;
    assign ctc_clear = (waveform_mode_field == `TMR8_WGM_CTC) && match && !block_reg;

    always @* begin
        counter_value_next = counter_value_reg;
        count_down_next    = count_down_reg;
        if (timer_tick) begin
            case (waveform_mode_field)
                `TMR8_WGM_NORMAL, `TMR8_WGM_FAST_PWM: begin
                    counter_value_next = counter_value_reg + 8'h01;
                    count_down_next    = 1'b0;
                end
                `TMR8_WGM_CTC: begin
                    count_down_next = 1'b0;
                    if (ctc_clear) begin
                        counter_value_next = `TMR8_BOTTOM;
                    end else begin
                        counter_value_next = counter_value_reg + 8'h01;
                    end
                end
                `TMR8_WGM_PHASE_PWM: begin
                    // turn at max and at bottom
                    if (!count_down_reg && at_max) begin
                        count_down_next    = 1'b1;
                        counter_value_next = counter_value_reg - 8'h01;
                    end else if (count_down_reg && at_bottom) begin
                        count_down_next    = 1'b0;
                        counter_value_next = counter_value_reg + 8'h01;
                    end else if (count_down_reg) begin
                        counter_value_next = counter_value_reg - 8'h01;
                    end else begin
                        counter_value_next = counter_value_reg + 8'h01;
                    end
                end
                default: counter_value_next = counter_value_reg;
            endcase
        end
        if (wr_counter) begin
            counter_value_next = reg_wdata;
        end
    end

    // overflow: wrap to zero, or turnaround at bottom in phase pwm
    assign overflow_evt = timer_tick && !wr_counter &&
                          ((waveform_mode_field == `TMR8_WGM_PHASE_PWM) ?
                           (count_down_reg && at_bottom) : at_max);

    // double buffer: phase pwm loads at max, fast pwm at the wrap to bottom
    assign buffer_load = timer_tick &&
                         (((waveform_mode_field == `TMR8_WGM_PHASE_PWM) && at_max) ||
                          ((waveform_mode_field == `TMR8_WGM_FAST_PWM) && at_max));

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            counter_value_reg  <= `TMR8_RST_COUNTER;
            count_down_reg     <= 1'b0;
            block_reg          <= 1'b0;
        end else begin
            counter_value_reg  <= counter_value_next;
            count_down_reg     <= count_down_next;
            if (wr_counter) begin
                block_reg <= 1'b1;
            end else if (timer_tick) begin
                block_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // control, compare and async registers
    // ****************************************
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            timer_control_reg  <= `TMR8_RST_CONTROL;
            clock_select_reg   <= `TMR8_RST_CLKSEL;
            compare_value_reg  <= `TMR8_RST_COMPARE;
            compare_buffer_reg <= `TMR8_RST_COMPARE;
            irq_mask_reg       <= `TMR8_RST_MASK;
            async_status_reg   <= `TMR8_RST_ASYNC;
        end else begin
            if (wr_control) begin
                timer_control_reg <= reg_wdata & 8'h33;
            end
            if (wr_clksel) begin
                clock_select_reg <= reg_wdata[`TMR8_CS_MSB:`TMR8_CS_LSB];
            end
            if (wr_compare) begin
                compare_buffer_reg <= reg_wdata;
            end
            // direct access outside pwm, buffered copy inside it
            if (wr_compare && !tmr8_is_pwm(waveform_mode_field)) begin
                compare_value_reg <= reg_wdata;
            end else if (buffer_load) begin
                compare_value_reg <= compare_buffer_reg;
            end
            if (wr_mask) begin
                irq_mask_reg <= {reg_wdata[`TMR8_BIT_CMP], reg_wdata[`TMR8_BIT_OVF]};
            end
            if (wr_async) begin
                async_status_reg <= {reg_wdata[`TMR8_BIT_EXT_CLK],
                                     reg_wdata[`TMR8_BIT_ASYNC_SEL]};
            end
        end
    end

    // ****************************************
    // interrupt flags
    // ****************************************
    // a set in the same cycle as a clear wins, so no event is lost
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_flag_reg <= `TMR8_RST_FLAGS;
        end else begin
            if (overflow_evt) begin
                irq_flag_reg[`TMR8_BIT_OVF] <= 1'b1;
            end else if ((wr_flag && reg_wdata[`TMR8_BIT_OVF]) || overflow_irq_ack) begin
                irq_flag_reg[`TMR8_BIT_OVF] <= 1'b0;
            end
            if (match_evt) begin
                irq_flag_reg[`TMR8_BIT_CMP] <= 1'b1;
            end else if (compare_irq_ack) begin
                irq_flag_reg[`TMR8_BIT_CMP] <= 1'b0;
            end else if (wr_flag && reg_wdata[`TMR8_BIT_CMP]) begin
                irq_flag_reg[`TMR8_BIT_CMP] <= 1'b0;
            end
        end
    end

    assign overflow_irq = irq_flag_reg[`TMR8_BIT_OVF] && overflow_irq_enable;
    assign compare_irq  = irq_flag_reg[`TMR8_BIT_CMP] && compare_irq_enable;

    // ****************************************
    // read port
    // ****************************************
    always @* begin
        rdata_next = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `TMR8_OFF_CONTROL: rdata_next = timer_control_reg;
                `TMR8_OFF_CLKSEL:  rdata_next = {5'h00, clock_select_reg};
                `TMR8_OFF_COUNTER: rdata_next = counter_value_reg;
                `TMR8_OFF_COMPARE: rdata_next = compare_buffer_reg;
                `TMR8_OFF_IRQ_FLAG: rdata_next = {6'h00, irq_flag_reg};
                `TMR8_OFF_IRQ_MASK: rdata_next = {6'h00, irq_mask_reg};
                `TMR8_OFF_ASYNC: begin
                    rdata_next[`TMR8_BIT_ASYNC_SEL] = async_clock_select;
                    rdata_next[`TMR8_BIT_EXT_CLK]   = ext_clock_select;
                    rdata_next[`TMR8_BIT_CNT_BUSY]  = block_reg;
                end
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    // ****************************************
    // waveform generator
    // ****************************************
    tmr8_wave u_wave (
        .sys_clk             (sys_clk),
        .rst_b               (rst_b),
        .tick                (timer_tick),
        .match_evt           (match_evt),
        .at_max              (at_max),
        .at_bottom           (at_bottom),
        .count_down          (count_down_reg),
        .waveform_mode_field (waveform_mode_field),
        .compare_output_mode (compare_output_mode),
        .oc_state            (oc_state)
    );

    // pin override follows any nonzero output mode, independent of waveform mode
    assign compare_output_pin      = oc_state;
    assign compare_output_override = |compare_output_mode;

endmodule

//--- tmr8_chk.sv
`timescale 1ns/10ps
`include "tmr8_defines.vh"

module tmr8_chk (
    input wire                    sys_clk,
    input wire                    rst_b,
    input wire [`TMR8_ADDR_W-1:0] reg_addr,
    input wire [7:0]              reg_wdata,
    input wire                    reg_wr,
    input wire                    reg_rd,
    input wire [7:0]              reg_rdata,
    input wire                    compare_irq,
    input wire                    compare_output_override,
    input wire                    count_at_bottom
);
    // ****************************************
    // clock select shadow, so a stopped timer is known
    // ****************************************
    reg  [2:0] cs_reg;
    wire       rd_cnt = reg_rd && !reg_wr && reg_addr == `TMR8_OFF_COUNTER;
    always @(posedge sys_clk or negedge rst_b)
        if (!rst_b) cs_reg <= 3'h0;
        else if (reg_wr && reg_addr == `TMR8_OFF_CLKSEL) cs_reg <= reg_wdata[2:0];

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    // ****************************************
    // assertions
    // ****************************************
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property (reg_rd && reg_addr == 3'h7 |=> reg_rdata == 8'h00)
        else $error("unmapped index read nonzero");
    a_bottom_level: assert property (rd_cnt |=> (reg_rdata == 8'h00) == $past(count_at_bottom))
        else $error("bottom flag disagrees with counter");
    a_cnt_wr_wins: assert property (reg_wr && reg_addr == `TMR8_OFF_COUNTER ##1 rd_cnt
        |=> reg_rdata == $past(reg_wdata, 2)) else $error("counter write lost");
    a_cmp_rw: assert property (reg_wr && reg_addr == `TMR8_OFF_COMPARE ##1
        reg_rd && reg_addr == `TMR8_OFF_COMPARE |=> reg_rdata == $past(reg_wdata, 2))
        else $error("compare value not read back");
    a_override_com: assert property (reg_wr && reg_addr == `TMR8_OFF_CONTROL
        |=> compare_output_override == (|$past(reg_wdata[5:4]))) else $error("override wrong");
    a_irq_has_flag: assert property (reg_rd && reg_addr == `TMR8_OFF_IRQ_FLAG && compare_irq
        |=> reg_rdata[1]) else $error("compare request without flag");
    a_stop_holds: assert property ((rd_cnt && cs_reg == 3'h0) ##1 (rd_cnt && cs_reg == 3'h0)
        |=> reg_rdata == $past(reg_rdata)) else $error("stopped counter moved");

    c_cmp_irq: cover property (compare_irq);
    c_bottom_left: cover property ($fell(count_at_bottom));
    c_override_on: cover property ($rose(compare_output_override));
endmodule

bind tmr8_core tmr8_chk i_tmr8_chk (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .compare_irq, .compare_output_override, .count_at_bottom);

//--- tb.sv
`timescale 1ns/10ps
`include "tmr8_defines.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end

module tb;
    reg        sys_clk, rst_b, reg_wr, reg_rd, crystal_in_pin, crystal_osc_clk;
    reg        overflow_irq_ack, compare_irq_ack;
    reg  [2:0] reg_addr;
    reg  [7:0] reg_wdata, d, v, w, k, e;
    wire [7:0] reg_rdata;
    wire       overflow_irq, compare_irq, compare_output_pin, compare_output_override, at_top;
    int        i, miscompares, total_checks, cyc;

    tmr8_core i_tmr8_core (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .crystal_in_pin, .crystal_osc_clk, .overflow_irq_ack, .compare_irq_ack,
        .overflow_irq, .compare_irq, .compare_output_pin, .compare_output_override,
        .count_at_top(at_top), .count_at_bottom());

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            report_and_stop;
        end
    end

    task wr(input [2:0] a, input [7:0] x);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= x;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task rd(input [2:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // back-to-back strobes: write then read, or two reads
    task wr_rd(input [2:0] a, input [7:0] x, input bit two);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= x;
        reg_wr <= !two;
        reg_rd <= two;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        #1 e = reg_rdata;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // bounded wait, a request that never comes is a mismatch
    task wait_irq(input bit cmp);
        int n;
        for (n = 0; n < 600 && (cmp ? compare_irq : overflow_irq) !== 1'b1; n++)
            @(posedge sys_clk);
        `CHK(cmp ? compare_irq : overflow_irq, 1'b1)
    endtask

    initial begin
        {rst_b, reg_wr, reg_rd, crystal_in_pin, crystal_osc_clk} = '0;
        {overflow_irq_ack, compare_irq_ack, reg_addr, reg_wdata} = '0;
        void'($urandom(32'h6250d8f9));
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'b1;
        for (i = 0; i < 8; i++) begin
            rd(i[2:0]);
            `CHK(d, 8'h00)
        end
        for (i = 0; i < 4; i++) begin
            wr(0, 8'(i * 8'h55));
            rd(0);
            `CHK(d, 8'(i * 8'h11))
            `CHK(compare_output_override, i != 0)
        end
        wr(0, 8'h00);
        wr(7, 8'hA5);
        rd(7);
        `CHK(d, 8'h00)
        for (i = 0; i < 16; i++) begin
            v = i ? $urandom : 8'hFF;
            w = $urandom;
            wr(2, v);
            wr_rd(3, w, 0);
            `CHK(d, w)
            repeat (3) @(posedge sys_clk);
            rd(2);
            `CHK(d, v)
            `CHK(at_top, v == 8'hFF)
            rd(3);
            `CHK(d, w)
            wr_rd(2, 8'h00, 1);
            `CHK(e, v)
            `CHK(d, v)
        end
        $display("test regs done");
        wr(3, 8'h80);
        wr(5, 8'h01);
        wr(2, 8'hFD);
        wr(1, 8'h01);
        wait_irq(0);
        wr(1, 8'h00);
        rd(2);
        `CHK(d < 8'h08, 1'b1)
        wr(4, 8'h00);
        rd(4);
        `CHK(d[0], 1'b1)
        wr(4, 8'h01);
        rd(4);
        `CHK(d[0], 1'b0)
        `CHK(overflow_irq, 1'b0)
        $display("test overflow done");
        k = 8'h03 + $urandom % 20;
        wr(0, 8'h02);
        wr(3, k);
        wr(2, 8'h00);
        wr(5, 8'h02);
        wr(1, 8'h01);
        wait_irq(1);
        `CHK(compare_output_pin, 1'b0)
        rd(4);
        `CHK(d[1], 1'b1)
        for (i = 0; i < 10; i++) begin
            rd(2);
            `CHK(d <= k, 1'b1)
        end
        wr_rd(2, 8'h40, 0);
        `CHK(d, 8'h40)
        wr(1, 8'h00);
        @(posedge sys_clk);
        compare_irq_ack <= 1'b1;
        @(posedge sys_clk);
        compare_irq_ack <= 1'b0;
        #1 `CHK(compare_irq, 1'b0)
        wr(0, 8'h32);
        wr(1, 8'h01);
        wait_irq(1);
        repeat (2) @(posedge sys_clk);
        `CHK(compare_output_pin, 1'b1)
        wr(1, 8'h00);
        wr(5, 8'h00);
        #1 `CHK(compare_irq, 1'b0)
        wr(4, 8'h02);
        rd(4);
        `CHK(d[1], 1'b0)
        wr(0, 8'h01);
        wr(2, 8'hFD);
        wr(1, 8'h01);
        repeat (4) @(posedge sys_clk);
        wr(1, 8'h00);
        rd(2);
        `CHK(d, 8'hFB)
        $display("test compare done");
        wr(0, 8'h00);
        wr(4, 8'h03);
        wr(2, k);
        wr(1, 8'h01);
        repeat (4) @(posedge sys_clk);
        wr(1, 8'h00);
        rd(4);
        `CHK(d[1], 1'b0)
        $display("test block done");
        for (i = 0; i < 2; i++) begin
            wr(6, i ? 8'h08 : 8'h18);
            wr(2, 8'h00);
            wr(1, 8'h01);
            repeat (2 * (7 + i)) begin
                repeat (4) @(posedge sys_clk);
                if (i) crystal_osc_clk <= ~crystal_osc_clk;
                else crystal_in_pin <= ~crystal_in_pin;
            end
            repeat (8) @(posedge sys_clk);
            wr(1, 8'h00);
            rd(2);
            `CHK(d, 8'(7 + i))
        end
        $display("test async done");
        report_and_stop;
    end
endmodule
